// ### src/urwe_ctrl.sv
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/1ps
// Overview of operation
// R01 - Setting standby suppresses every receiver request until a wakeup clears it.
// R02 - Address-mark wakeup: character with MSB 1 clears standby and sets receiver full.
// R03 - Software may compare address and set standby again on mismatch.
// R04 - Idle-line wakeup: idle character clears standby, sets neither idle nor full.
// R05 - Idle count type picks counting start: after start bit or after stop bit.
// R06 - Idle-line wakeup: setting standby while line already idle wakes again.
// R07 - Character moved to buffer sets receiver full; enable gates receive request.
// R08 - Idle flag after 10 or 11 ones; idle enable gates receive request.
// R09 - Character arriving while buffer full sets overrun, keeps old, drops new.
// R10 - Noise in start, data or stop bits sets noise flag, gated request.
// R11 - Zero where stop bit expected sets framing flag, gated request.
// R12 - Failed parity check sets parity flag, gated error request.
// R13 - Block keeps running in wait; enabled requests raise the wake output.
// R14 - Stop mode freezes all state; operation resumes afterwards.
// R15 - Break with clear enable 1: status clears work and stay cleared.
// R16 - Break with clear enable 0: status untouched; pending two-step finishes later.
// R17 - Enabled module forces transmit pin output, receive pin input.
// R18 - Loop mode feeds transmitter output to receiver; both must be enabled.
// R19 - Module enable runs block; clearing sets empty, complete, masks tx requests.
// R20 - Transmit inversion inverts every transmitted level including idle.
// R21 - Length select gives 10 or 11 bit frames; parity in last data position.
// R22 - Wake select 1 address mark, 0 idle; reset clears control one.
// R23 - Idle type 1 counts after stop bit, 0 after start bit; reset clears.
// R24 - Parity occupies the character MSB; parity type 1 odd, 0 even.
// R25 - Receive request ORs gated full and idle; error request ORs gated errors.
module urwe_ctrl
  import urwe_pkg::*;
#(
  parameter int BIT_CYCLES = BIT_CYCLES_DEFAULT
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Chip state
  input wire logic stop_mode,
  input wire logic debug_break,
  // Shared port settings
  input wire logic [1:0] port_direction_reg,
  input wire logic [1:0] port_data,
  // Transmit pin, shared with port_bit_zero
  input wire logic txd_pin_in,
  output logic txd_pin_out,
  output logic txd_pin_oe_n,
  // Receive pin, shared with port_bit_one
  input wire logic rxd_pin_in,
  output logic rxd_pin_out,
  output logic rxd_pin_oe_n,
  // Requests
  output logic rx_irq,
  output logic err_irq,
  output logic tx_irq,
  output logic wake_req
);

  localparam logic [7:0] LAST = 8'(BIT_CYCLES - 1);
  localparam logic [7:0] MID = 8'((BIT_CYCLES - 1) / 2);

  logic [7:0] serial_control_one;
  logic [7:0] serial_control_two;
  logic [7:0] serial_control_three;
  logic [7:0] break_flag_control;
  logic [7:0] serial_data_buffer;
  logic rx_bit8;
  logic tx_empty_flag, tx_complete_flag, rx_full_flag, idle_flag;
  logic overrun_flag, noise_flag, framing_err_flag, parity_err_flag;
  logic arm_rx, arm_tx;
  urwe_rx_state_e rx_state;
  logic [7:0] rx_div;
  logic [2:0] rx_samp;
  logic [3:0] rx_idx;
  logic [8:0] rx_sr;
  logic rx_noise_acc, rx_prev;
  logic rx_done, rx_stop_bad, rx_noisy;
  logic [3:0] ones_cnt;
  logic idle_armed;
  logic tx_busy, tx_pending, tx_raw, tx_done;
  logic [8:0] tx_buf;
  logic [10:0] tx_sh;
  logic [3:0] tx_cnt;
  logic [7:0] tx_div;

  // Named control fields
  logic loopback_select, module_enable, tx_invert, long_char;
  logic wake_addr, idle_count_type, parity_on, parity_odd_select;
  logic tx_en, rx_en, rx_standby, send_break;
  logic break_clear_enable;
  assign loopback_select = serial_control_one[C1_LOOP];
  assign module_enable = serial_control_one[C1_ENABLE];
  assign tx_invert = serial_control_one[C1_INVERT];
  assign long_char = serial_control_one[C1_LONG];
  assign wake_addr = serial_control_one[C1_WAKE_ADDR];
  assign idle_count_type = serial_control_one[C1_IDLE_TYPE];
  assign parity_on = serial_control_one[C1_PAR_ON];
  assign parity_odd_select = serial_control_one[C1_PAR_ODD];
  assign tx_en = serial_control_two[C2_TX_EN];
  assign rx_en = serial_control_two[C2_RX_EN];
  assign rx_standby = serial_control_two[C2_STANDBY];
  assign send_break = serial_control_two[C2_BREAK];
  assign break_clear_enable = break_flag_control[BRK_CLR_EN];

  // Stop mode stands in for the gated module clock; nothing moves meanwhile
  logic run;
  // R14 stop freezes state
  assign run = ~stop_mode;

  // Bus decode
  logic rd_status, rd_data, wr_data, access_ok;
  assign rd_status = reg_rd && reg_addr == OFS_STATUS;
  assign rd_data = reg_rd && reg_addr == OFS_DATA;
  assign wr_data = reg_wr && reg_addr == OFS_DATA;
  // R15 R16 break protects status
  assign access_ok = ~debug_break | break_clear_enable;

  // Receive source and bit timing
  logic rx_active, rx_src, bit_end, maj, noisy;
  logic [3:0] nbits, thr;
  // R18 loop input select
  assign rx_src = loopback_select ? tx_raw : rxd_pin_in;
  assign rx_active = module_enable & rx_en & (~loopback_select | tx_en);
  assign bit_end = rx_div == LAST;
  assign maj = (rx_samp[0] & rx_samp[1]) | (rx_samp[0] & rx_samp[2]) | (rx_samp[1] & rx_samp[2]);
  assign noisy = (|rx_samp) & ~(&rx_samp);
  // R21 character length
  assign nbits = long_char ? DATA_LONG : DATA_SHORT;
  assign thr = long_char ? FRAME_LONG : FRAME_SHORT;

  // Receive character decisions
  logic rx_msb, accept, load, ovr_set, wake_am, wake_idle, par_bad, idle_reached;
  assign rx_msb = rx_sr[8];
  // R02 address mark lets the character through
  assign accept = rx_done & (~rx_standby | (wake_addr & rx_msb));
  assign wake_am = rx_done & rx_standby & wake_addr & rx_msb;
  assign load = accept & ~rx_full_flag;
  // R09 overrun keeps old character
  assign ovr_set = accept & rx_full_flag;
  // R12 R24 parity over full character
  assign par_bad = parity_on & ((long_char ? ^rx_sr : ^rx_sr[8:1]) != parity_odd_select);
  assign idle_reached = ones_cnt >= thr;
  // R04 R06 idle wakes standby
  assign wake_idle = rx_standby & ~wake_addr & idle_reached & rx_active;

  // Two-step clears: status read arms, data access completes
  logic clr_rx, clr_tx;
  assign clr_rx = rd_data & access_ok & arm_rx;
  assign clr_tx = wr_data & access_ok & arm_tx;

  // Requests; standby mutes both receiver groups
  logic rx_req, err_req, tx_req;
  // R01 R25 gated receiver requests
  assign rx_req = ~rx_standby & ((rx_full_flag & serial_control_two[C2_RX_IE]) |
                                 (idle_flag & serial_control_two[C2_IDLE_IE]));
  assign err_req = ~rx_standby & ((overrun_flag & serial_control_three[C3_OVR_IE]) |
                                  (noise_flag & serial_control_three[C3_NOISE_IE]) |
                                  (framing_err_flag & serial_control_three[C3_FRAME_IE]) |
                                  (parity_err_flag & serial_control_three[C3_PAR_IE]));
  // R19 transmitter requests masked when disabled
  assign tx_req = module_enable & ((tx_empty_flag & serial_control_two[C2_TX_IE]) |
                                   (tx_complete_flag & serial_control_two[C2_TC_IE]));

  // Transmit frame assembly, LSB first with start bit at bit 0
  function automatic logic [10:0] tx_frame(input logic lng, input logic pon,
                                            input logic podd, input logic [8:0] d);
    logic [8:0] p;
    p = d;
    if (pon && lng)
      p[8] = (^d[7:0]) ^ podd;
    else if (pon)
      p[7] = (^d[6:0]) ^ podd;
    if (lng)
      tx_frame = {1'b1, p, 1'b0};
    else
      tx_frame = {2'b11, p[7:0], 1'b0};
  endfunction

  // Control one and break control
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      // R22 reset clears control one
      serial_control_one <= CTRL_ONE_RST;
      break_flag_control <= BRK_CTRL_RST;
    end
    else if (run)
    begin
      if (reg_wr && reg_addr == OFS_CTRL_ONE)
        serial_control_one <= reg_wdata;
      if (reg_wr && reg_addr == OFS_BRK_CTRL)
        break_flag_control <= reg_wdata & 8'h80;
    end
  end

  // Control two; standby is cleared by wakeups, software set beats them
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      serial_control_two <= CTRL_TWO_RST;
    else if (run)
    begin
      if (reg_wr && reg_addr == OFS_CTRL_TWO)
      begin
        serial_control_two <= reg_wdata;
        // Enables only change while the module is enabled
        if (!module_enable)
        begin
          serial_control_two[C2_TX_EN] <= tx_en;
          serial_control_two[C2_RX_EN] <= rx_en;
        end
      end
      // R01 R02 R04 wakeup clears standby
      else if (wake_am || wake_idle)
        serial_control_two[C2_STANDBY] <= 1'b0;
    end
  end

  // Control three and received ninth bit
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      serial_control_three <= CTRL_THREE_RST;
      rx_bit8 <= 1'b0;
    end
    else if (run)
    begin
      if (reg_wr && reg_addr == OFS_CTRL_THREE)
        serial_control_three <= reg_wdata & C3_WMASK;
      if (load)
        rx_bit8 <= rx_sr[8];
    end
  end

  // Receiver sequence: three samples mid-bit, majority decides
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_state <= RX_IDLE;
      rx_div <= 8'h00;
      rx_samp <= 3'h7;
      rx_idx <= 4'h0;
      rx_sr <= 9'h000;
      rx_noise_acc <= 1'b0;
      rx_prev <= 1'b1;
      rx_done <= 1'b0;
      rx_stop_bad <= 1'b0;
      rx_noisy <= 1'b0;
    end
    else if (run)
    begin
      rx_done <= 1'b0;
      rx_prev <= rx_src;
      if (rx_div == MID - 8'h01 || rx_div == MID || rx_div == MID + 8'h01)
        rx_samp <= {rx_samp[1:0], rx_src};
      rx_div <= bit_end ? 8'h00 : rx_div + 8'h01;
      if (!rx_active)
        rx_state <= RX_IDLE;
      else
        case (rx_state)
          RX_IDLE:
            if (rx_prev && !rx_src)
            begin
              rx_state <= RX_START;
              rx_div <= 8'h00;
              rx_sr <= 9'h000;
            end
          RX_START:
            if (bit_end)
            begin
              rx_state <= maj ? RX_IDLE : RX_DATA;
              rx_idx <= 4'h0;
              // R10 start bit noise
              rx_noise_acc <= noisy;
            end
          RX_DATA:
            if (bit_end)
            begin
              rx_sr <= {maj, rx_sr[8:1]};
              rx_noise_acc <= rx_noise_acc | noisy;
              rx_idx <= rx_idx + 4'h1;
              if (rx_idx == nbits - 4'h1)
                rx_state <= RX_STOP;
            end
          RX_STOP:
            if (bit_end)
            begin
              rx_state <= RX_IDLE;
              rx_done <= 1'b1;
              // R11 zero in stop position
              rx_stop_bad <= ~maj;
              rx_noisy <= rx_noise_acc | noisy;
            end
          default:
            rx_state <= RX_IDLE;
        endcase
    end
  end

  // Idle line counter; type decides whether frame bits count
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ones_cnt <= 4'h0;
      idle_armed <= 1'b0;
    end
    else if (run)
    begin
      if (rx_state == RX_IDLE && rx_active && rx_prev && !rx_src)
        ones_cnt <= 4'h0;
      else if (bit_end && rx_active)
      begin
        // R05 R23 idle counting start point
        if (rx_state == RX_IDLE || (!idle_count_type && rx_state != RX_START))
          ones_cnt <= !maj ? 4'h0 : (ones_cnt == 4'hF ? ones_cnt : ones_cnt + 4'h1);
        else
          ones_cnt <= 4'h0;
      end
      // One idle report per received character
      if (rx_done)
        idle_armed <= 1'b1;
      else if (idle_reached || wake_idle)
        idle_armed <= 1'b0;
    end
  end

  // Two-step clear arming, frozen during a protected break
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      arm_rx <= 1'b0;
      arm_tx <= 1'b0;
    end
    else if (run && access_ok)
    begin
      // R16 arming survives the break
      if (rd_status)
        arm_rx <= 1'b1;
      else if (rd_data)
        arm_rx <= 1'b0;
      if (rd_status)
        arm_tx <= 1'b1;
      else if (wr_data)
        arm_tx <= 1'b0;
    end
  end

  // Receiver status flags and data buffer; set beats clear
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_full_flag <= 1'b0;
      idle_flag <= 1'b0;
      overrun_flag <= 1'b0;
      noise_flag <= 1'b0;
      framing_err_flag <= 1'b0;
      parity_err_flag <= 1'b0;
      serial_data_buffer <= 8'h00;
    end
    else if (run)
    begin
      // R07 buffer load sets full
      rx_full_flag <= load | (rx_full_flag & ~clr_rx);
      // R08 R04 idle flag, not on wakeup
      idle_flag <= (idle_reached & idle_armed & ~rx_standby) | (idle_flag & ~clr_rx);
      overrun_flag <= ovr_set | (overrun_flag & ~clr_rx);
      noise_flag <= (load & rx_noisy) | (noise_flag & ~clr_rx);
      framing_err_flag <= (load & rx_stop_bad) | (framing_err_flag & ~clr_rx);
      parity_err_flag <= (load & par_bad) | (parity_err_flag & ~clr_rx);
      if (load)
        serial_data_buffer <= long_char ? rx_sr[7:0] : rx_sr[8:1];
    end
  end

  // Transmitter: one buffered character behind the shifter
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_busy <= 1'b0;
      tx_pending <= 1'b0;
      tx_raw <= 1'b1;
      tx_done <= 1'b0;
      tx_buf <= 9'h000;
      tx_sh <= 11'h7FF;
      tx_cnt <= 4'h0;
      tx_div <= 8'h00;
    end
    else if (run)
    begin
      tx_done <= 1'b0;
      if (wr_data)
        tx_buf <= {serial_control_three[C3_T8], reg_wdata};
      if (!module_enable)
      begin
        tx_busy <= 1'b0;
        tx_pending <= 1'b0;
        tx_raw <= 1'b1;
      end
      else if (tx_busy)
      begin
        if (wr_data && tx_en)
          tx_pending <= 1'b1;
        tx_div <= tx_div == LAST ? 8'h00 : tx_div + 8'h01;
        if (tx_div == LAST && tx_cnt == 4'h1)
        begin
          tx_busy <= 1'b0;
          tx_raw <= 1'b1;
          tx_done <= ~tx_pending;
        end
        else if (tx_div == LAST)
        begin
          tx_sh <= {1'b1, tx_sh[10:1]};
          tx_raw <= tx_sh[1];
          tx_cnt <= tx_cnt - 4'h1;
        end
      end
      else if (tx_pending && tx_en)
      begin
        // R21 R24 frame with parity in MSB
        tx_sh <= tx_frame(long_char, parity_on, parity_odd_select, tx_buf);
        tx_raw <= 1'b0;
        tx_cnt <= thr;
        tx_div <= 8'h00;
        tx_busy <= 1'b1;
        tx_pending <= 1'b0;
      end
      else
      begin
        tx_pending <= wr_data & tx_en;
        tx_raw <= ~(send_break & tx_en);
      end
    end
  end

  // Transmitter flags
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_empty_flag <= 1'b1;
      tx_complete_flag <= 1'b1;
    end
    else if (run)
    begin
      // R19 disable sets empty and complete
      tx_empty_flag <= ~module_enable | (~tx_busy & tx_pending & tx_en) |
                       (tx_empty_flag & ~clr_tx);
      tx_complete_flag <= ~module_enable | tx_done |
                          (tx_complete_flag & ~clr_tx & ~(tx_pending & tx_en));
    end
  end

  // Register read, data stands one cycle after the strobe
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= 8'h00;
    else if (run && reg_rd)
      case (reg_addr)
        OFS_CTRL_ONE: reg_rdata <= serial_control_one;
        OFS_CTRL_TWO: reg_rdata <= serial_control_two;
        OFS_CTRL_THREE: reg_rdata <= {rx_bit8, serial_control_three[6:0]};
        OFS_STATUS: reg_rdata <= {tx_empty_flag, tx_complete_flag, rx_full_flag, idle_flag,
                                  overrun_flag, noise_flag, framing_err_flag, parity_err_flag};
        OFS_DATA: reg_rdata <= serial_data_buffer;
        OFS_BRK_CTRL: reg_rdata <= break_flag_control;
        default: reg_rdata <= 8'h00;
      endcase
  end

  // Pin ownership; port direction only matters while the module is off
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      txd_pin_out <= 1'b1;
      txd_pin_oe_n <= 1'b1;
      rxd_pin_out <= 1'b1;
      rxd_pin_oe_n <= 1'b1;
    end
    else if (run)
    begin
      // R17 R20 forced directions, inverted line
      txd_pin_out <= module_enable ? (tx_raw ^ tx_invert) : port_data[0];
      txd_pin_oe_n <= module_enable ? 1'b0 : ~port_direction_reg[0];
      rxd_pin_out <= port_data[1];
      rxd_pin_oe_n <= module_enable ? 1'b1 : ~port_direction_reg[1];
    end
  end

  // Request outputs; wake output serves wait-mode exit
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_irq <= 1'b0;
      err_irq <= 1'b0;
      tx_irq <= 1'b0;
      wake_req <= 1'b0;
    end
    else if (run)
    begin
      // R25 request outputs
      rx_irq <= rx_req;
      err_irq <= err_req;
      tx_irq <= tx_req;
      // R13 enabled request wakes processor
      wake_req <= rx_req | err_req | tx_req;
    end
  end

endmodule // urwe_ctrl

// ### pkg/urwe_pkg.sv
package urwe_pkg;
  // Register offsets on the plain register port
  localparam logic [2:0] OFS_CTRL_ONE = 3'h0;
  localparam logic [2:0] OFS_CTRL_TWO = 3'h1;
  localparam logic [2:0] OFS_CTRL_THREE = 3'h2;
  localparam logic [2:0] OFS_STATUS = 3'h3;
  localparam logic [2:0] OFS_DATA = 3'h4;
  localparam logic [2:0] OFS_BRK_CTRL = 3'h5;
  // serial_control_one fields
  localparam int C1_LOOP = 7;
  localparam int C1_ENABLE = 6;
  localparam int C1_INVERT = 5;
  localparam int C1_LONG = 4;
  localparam int C1_WAKE_ADDR = 3;
  localparam int C1_IDLE_TYPE = 2;
  localparam int C1_PAR_ON = 1;
  localparam int C1_PAR_ODD = 0;
  // serial_control_two fields
  localparam int C2_TX_IE = 7;
  localparam int C2_TC_IE = 6;
  localparam int C2_RX_IE = 5;
  localparam int C2_IDLE_IE = 4;
  localparam int C2_TX_EN = 3;
  localparam int C2_RX_EN = 2;
  localparam int C2_STANDBY = 1;
  localparam int C2_BREAK = 0;
  // serial_control_three fields (bit 7 is the received ninth bit)
  localparam int C3_T8 = 6;
  localparam int C3_OVR_IE = 3;
  localparam int C3_NOISE_IE = 2;
  localparam int C3_FRAME_IE = 1;
  localparam int C3_PAR_IE = 0;
  localparam logic [7:0] C3_WMASK = 8'h4F;
  // break_flag_control field
  localparam int BRK_CLR_EN = 7;
  // Values after reset
  localparam logic [7:0] CTRL_ONE_RST = 8'h00;
  localparam logic [7:0] CTRL_TWO_RST = 8'h00;
  localparam logic [7:0] CTRL_THREE_RST = 8'h00;
  localparam logic [7:0] BRK_CTRL_RST = 8'h00;
  // Frame lengths in bit times, and data bit counts
  localparam logic [3:0] FRAME_SHORT = 4'hA;
  localparam logic [3:0] FRAME_LONG = 4'hB;
  localparam logic [3:0] DATA_SHORT = 4'h8;
  localparam logic [3:0] DATA_LONG = 4'h9;
  // Clock cycles per bit time
  localparam int BIT_CYCLES_DEFAULT = 16;
  // Receiver sequence
  typedef enum logic [3:0] {
    RX_IDLE = 4'h1,
    RX_START = 4'h2,
    RX_DATA = 4'h4,
    RX_STOP = 4'h8
  } urwe_rx_state_e;
endpackage

// ### dv/urwe_peer.sv
`timescale 1ns/1ps
module urwe_peer
  import urwe_pkg::*;
#(
  parameter int BIT_CYCLES = 4
)
(
  // Clock
  input wire logic clk,
  // Serial line toward the receive pin
  output logic line
);
  // Mark level between frames, as a real transmitter keeps it
  initial line = 1'b1;
  // ten bit frame
  // Start low, data LSB first, chosen stop level; a low stop forces a framing fault
  task automatic send_char(input logic [7:0] data, input logic stop_lvl);
    logic [9:0] frame;
    frame = {stop_lvl, data, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      line <= frame[i];
      repeat (BIT_CYCLES) @(posedge clk);
    end
    line <= 1'b1;
  endtask
endmodule // urwe_peer

// ### dv/urwe_ctrl_chk.sv
`timescale 1ns/1ps
module urwe_ctrl_chk
  import urwe_pkg::*;
#(
  parameter int BIT_CYCLES = BIT_CYCLES_DEFAULT
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Chip state and port settings
  input wire logic stop_mode,
  input wire logic [1:0] port_direction_reg,
  input wire logic [1:0] port_data,
  // Pins and requests
  input wire logic txd_pin_out,
  input wire logic txd_pin_oe_n,
  input wire logic rxd_pin_oe_n,
  input wire logic rx_irq,
  input wire logic err_irq,
  input wire logic tx_irq,
  input wire logic wake_req
);
  logic [7:0] c1_sh;
  logic [3:0] c3_sh;
  logic [1:0] age;
  // Shadow control writes; age keeps $past away from reset values
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      c1_sh <= CTRL_ONE_RST;
      c3_sh <= 4'h0;
      age <= 2'h0;
    end
    else
    begin
      if (reg_wr && !stop_mode && reg_addr == OFS_CTRL_ONE)
        c1_sh <= reg_wdata;
      if (reg_wr && !stop_mode && reg_addr == OFS_CTRL_THREE)
        c3_sh <= reg_wdata[3:0];
      if (age != 2'h3)
        age <= age + 2'h1;
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  chk_ctrl_one_read: assert property (
    reg_rd && !stop_mode && reg_addr == OFS_CTRL_ONE |=> reg_rdata == c1_sh)
    else $error("control one readback wrong");
  chk_pins_enabled: assert property (
    age == 2'h3 && c1_sh[C1_ENABLE] && $past(c1_sh[C1_ENABLE]) |-> !txd_pin_oe_n && rxd_pin_oe_n)
    else $error("pin directions wrong while enabled");
  chk_pins_port: assert property (
    age == 2'h3 && !c1_sh[C1_ENABLE] && !$past(c1_sh[C1_ENABLE])
    |-> rxd_pin_oe_n == ~$past(port_direction_reg[1]) && txd_pin_out == $past(port_data[0]))
    else $error("port settings not on pins while disabled");
  chk_wake_or: assert property (wake_req == (rx_irq || err_irq || tx_irq))
    else $error("wake request not the OR of requests");
  chk_stop_hold: assert property (stop_mode && reg_rd |=> $stable(reg_rdata))
    else $error("read served in stop mode");
  chk_standby_mute: assert property (
    reg_wr && !stop_mode && reg_addr == OFS_CTRL_TWO && reg_wdata[C2_STANDBY]
    && c1_sh[C1_WAKE_ADDR] |-> ##2 (!rx_irq && !err_irq) [*2])
    else $error("request seen in standby");
  chk_err_masked: assert property (c3_sh == 4'h0 && $past(c3_sh) == 4'h0 |-> !err_irq)
    else $error("error request with all enables off");
  chk_tx_masked: assert property (
    !c1_sh[C1_ENABLE] && !$past(c1_sh[C1_ENABLE]) |-> !tx_irq)
    else $error("transmit request while disabled");
  // Main scenarios reached
  cov_rx_irq: cover property ($rose(rx_irq));
  cov_err_irq: cover property ($rose(err_irq));
  cov_stop_read: cover property (stop_mode && reg_rd);
endmodule // urwe_ctrl_chk
bind urwe_ctrl urwe_ctrl_chk #(.BIT_CYCLES(BIT_CYCLES)) u_urwe_ctrl_chk (.clk(clk),
  .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .stop_mode(stop_mode),
  .port_direction_reg(port_direction_reg), .port_data(port_data), .txd_pin_out(txd_pin_out),
  .txd_pin_oe_n(txd_pin_oe_n), .rxd_pin_oe_n(rxd_pin_oe_n), .rx_irq(rx_irq),
  .err_irq(err_irq), .tx_irq(tx_irq), .wake_req(wake_req));

// ### dv/tb_urwe_ctrl.sv
`timescale 1ns/1ps
module tb_urwe_ctrl;
  import urwe_pkg::*;
  localparam int BC = 4;
  logic clk, reset_n, reg_wr, reg_rd, stop_mode, debug_break, serial_line;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, got;
  logic [1:0] port_direction_reg, port_data;
  logic txd_pin_out, txd_pin_oe_n, rxd_pin_out, rxd_pin_oe_n, rx_irq, err_irq, tx_irq, wake_req;
  int fail_count, compares;
  urwe_ctrl #(.BIT_CYCLES(BC)) u_urwe_ctrl (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .stop_mode(stop_mode), .debug_break(debug_break), .port_direction_reg(port_direction_reg),
    .port_data(port_data), .txd_pin_in(txd_pin_out), .txd_pin_out(txd_pin_out),
    .txd_pin_oe_n(txd_pin_oe_n), .rxd_pin_in(serial_line), .rxd_pin_out(rxd_pin_out),
    .rxd_pin_oe_n(rxd_pin_oe_n), .rx_irq(rx_irq), .err_irq(err_irq), .tx_irq(tx_irq),
    .wake_req(wake_req));
  urwe_peer #(.BIT_CYCLES(BC)) u_urwe_peer (.clk(clk), .line(serial_line));
  // 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Idle cycle after the strobe avoids a double assignment
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [2:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    got = reg_rdata;
  endtask
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] seen);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Masked read so flags outside the scenario do not matter
  task automatic rdc(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e, input string n);
    rd(a);
    cmp(n, e, got & m);
  endtask
  // Frame plus the flag latency, with margin
  task automatic send(input logic [7:0] d, input logic stop_lvl);
    u_urwe_peer.send_char(d, stop_lvl);
    repeat (8) @(posedge clk);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog far beyond the test length
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    final_report();
  end
  // Test sequence
  initial
  begin
    {reset_n, reg_wr, reg_rd, stop_mode, debug_break} = 5'h00;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    port_direction_reg = 2'h2;
    port_data = 2'h2;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rdc(OFS_CTRL_ONE, 8'hFF, CTRL_ONE_RST, "ctrl_one");
    rdc(OFS_STATUS, 8'hFF, 8'hC0, "status");
    cmp("rx_pins", 8'h02, {6'h0, rxd_pin_out, rxd_pin_oe_n});
    wr(OFS_CTRL_ONE, 8'h40);
    wr(OFS_CTRL_TWO, 8'h2C);
    wr(OFS_CTRL_THREE, 8'h0F);
    cmp("pins_on", 8'h05, {5'h0, rxd_pin_oe_n, txd_pin_oe_n, txd_pin_out});
    wr(OFS_CTRL_ONE, 8'h60);
    @(posedge clk);
    cmp("tx_inv", 8'h00, {7'h0, txd_pin_out});
    wr(OFS_CTRL_ONE, 8'h40);
    send(8'h5A, 1'b1);
    cmp("rx_irq", 8'h01, {7'h0, rx_irq});
    rdc(OFS_STATUS, 8'h2F, 8'h20, "full");
    rdc(OFS_DATA, 8'hFF, 8'h5A, "data");
    rdc(OFS_STATUS, 8'h20, 8'h00, "full_clr");
    send(8'h11, 1'b1);
    send(8'h22, 1'b1);
    cmp("err_ovr", 8'h01, {7'h0, err_irq});
    rdc(OFS_STATUS, 8'h28, 8'h28, "overrun");
    rdc(OFS_DATA, 8'hFF, 8'h11, "old_data");
    send(8'h33, 1'b0);
    cmp("err_frm", 8'h01, {7'h0, err_irq});
    rdc(OFS_STATUS, 8'h02, 8'h02, "framing");
    rd(OFS_DATA);
    // Even then odd parity on a character with one set bit
    for (int k = 0; k < 2; k++)
    begin
      wr(OFS_CTRL_ONE, 8'h42 | 8'(k));
      send(8'h01, 1'b1);
      rdc(OFS_STATUS, 8'h01, (k == 0) ? 8'h01 : 8'h00, "parity");
      rd(OFS_DATA);
    end
    wr(OFS_CTRL_ONE, 8'h48);
    wr(OFS_CTRL_TWO, 8'h2E);
    send(8'h12, 1'b1);
    rdc(OFS_STATUS, 8'h20, 8'h00, "standby");
    send(8'h92, 1'b1);
    rdc(OFS_CTRL_TWO, 8'h02, 8'h00, "woken");
    rdc(OFS_STATUS, 8'h20, 8'h20, "mark_full");
    debug_break <= 1'b1;
    rdc(OFS_DATA, 8'hFF, 8'h92, "mark_data");
    debug_break <= 1'b0;
    rdc(OFS_STATUS, 8'h20, 8'h20, "brk_keep");
    rd(OFS_DATA);
    rdc(OFS_STATUS, 8'h20, 8'h00, "brk_done");
    wr(OFS_CTRL_TWO, 8'h2E);
    rdc(OFS_CTRL_TWO, 8'h02, 8'h02, "restandby");
    wr(OFS_BRK_CTRL, 8'h80);
    send(8'h81, 1'b1);
    rd(OFS_STATUS);
    debug_break <= 1'b1;
    rd(OFS_DATA);
    debug_break <= 1'b0;
    rdc(OFS_STATUS, 8'h20, 8'h00, "brk_clr");
    stop_mode <= 1'b1;
    wr(OFS_CTRL_ONE, 8'h00);
    rd(OFS_CTRL_ONE);
    stop_mode <= 1'b0;
    rdc(OFS_CTRL_ONE, 8'hFF, 8'h48, "stop_keep");
    final_report();
  end
endmodule // tb_urwe_ctrl
